// ==== design/hbr_defines.vh ====
// Constants for the host buffer RAM access port: command codes, bit positions, sizes.
`ifndef HBR_DEFINES_VH
`define HBR_DEFINES_VH

// Command byte layout: bit 7 selects a write, bits 6..0 select the target.
`define HBR_CMD_WRITE_BIT   7
`define HBR_CMD_XFER_COUNT  7'h22
`define HBR_CMD_IRQ_STATUS  7'h24
`define HBR_CMD_ISO_LENGTH  7'h2A
`define HBR_CMD_ACK_LENGTH  7'h2B
`define HBR_CMD_BUF_STATE   7'h2C
`define HBR_CMD_ISO_PORT    7'h40
`define HBR_CMD_ACK_PORT    7'h41

// Interrupt status bit positions.
`define HBR_IRQ_ACK_READY   1
`define HBR_IRQ_ALL_DONE    2

// Buffer state register bit positions.
`define HBR_BS_ISO_A_FULL   0
`define HBR_BS_ISO_B_FULL   1
`define HBR_BS_ACK_LOADED   2
`define HBR_BS_ISO_A_DONE   3
`define HBR_BS_ISO_B_DONE   4
`define HBR_BS_ACK_DONE     5

// Buffer RAM geometry and reset values.
`define HBR_RAM_BYTES       4096
`define HBR_ADDR_W          12
`define HBR_LEN_W           13
`define HBR_FIFO_DEPTH      8
`define HBR_ACK_LEN_RST     13'h1000
`define HBR_ISO_LEN_RST     13'h0000
`define HBR_XFER_CNT_RST    16'h0000

`endif

// ==== design/hbr_fifo.v ====
// Write-data FIFO between the processor access port and the buffer RAM.
`timescale 1ns/1ps

module hbr_fifo #(
    parameter WIDTH = 30,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk,
    input  wire             rst,
    input  wire             in_valid,
    output reg              in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;

    wire            push = in_valid & in_ready;
    wire            pop  = out_valid & out_ready;
    wire [AW:0]     next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];

    // Ready is a registered not-full so the producer never sees a combinational path.
    always @(posedge clk) begin
        if (rst) begin
            wr_ptr   <= {AW{1'b0}};
            rd_ptr   <= {AW{1'b0}};
            count    <= {(AW+1){1'b0}};
            in_ready <= 1'b1;
        end else begin
            if (push) begin
                mem[wr_ptr] <= in_data;
                wr_ptr      <= (wr_ptr == DEPTH - 1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == DEPTH - 1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            count    <= next_count;
            in_ready <= (next_count != DEPTH);
        end
    end

endmodule // hbr_fifo

// ==== design/hbr_word_ram.v ====
// Byte-organised buffer RAM stored as 16-bit words, even byte in the low lane.
`timescale 1ns/1ps

module hbr_word_ram #(
    parameter BYTES = 4096,
    parameter WAW   = 11
) (
    input  wire           clk,
    input  wire           wr_en,
    input  wire [WAW-1:0] wr_addr,
    input  wire [15:0]    wr_data,
    input  wire [WAW-1:0] rd_addr,
    output wire [15:0]    rd_data
);

    reg [15:0] mem [0:BYTES/2-1];

    // Low byte is the even location, high byte the odd one that follows.
    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Asynchronous read; the caller registers the result.
    assign rd_data = mem[rd_addr];

endmodule // hbr_word_ram

// ==== design/hbr_access_port.v ====
// Host buffer RAM access logic: command decode, access ports, pointer and buffer flags.
`timescale 1ns/1ps
`include "hbr_defines.vh"

////////////////////////////////////////////////////////////////////////////////
module hbr_access_port #(
    parameter RAM_BYTES  = `HBR_RAM_BYTES,
    parameter FIFO_DEPTH = `HBR_FIFO_DEPTH
) (
    input  wire        clk,
    input  wire        rst,
    input  wire        cmd_wr,
    input  wire        data_wr,
    input  wire        data_rd,
    input  wire [15:0] data_in,
    output reg  [15:0] data_out,
    output reg         data_out_valid,
    output wire        wr_ready,
    output reg         idle,
    input  wire        operational_state,
    input  wire        sof,
    input  wire        engine_ram_busy,
    input  wire        engine_ack_done,
    input  wire        engine_iso_done,
    output reg         ack_start,
    output reg         iso_start,
    output reg         iso_cpu_half
);

    localparam FW = 30;

    ////////////////////////////////////////////////////////////////////////////
    // Registers.
    reg  [7:0]                 cmd;
    reg  [15:0]                transfer_byte_count;
    reg  [`HBR_LEN_W-1:0]      ack_len;
    reg  [`HBR_LEN_W-1:0]      iso_len;
    reg  [`HBR_LEN_W-1:0]      ptr;
    reg                        ack_list_ready_flag;
    reg                        all_transfers_done_flag;
    reg                        iso_half_a_full;
    reg                        iso_half_b_full;
    reg                        iso_half_a_done;
    reg                        iso_half_b_done;
    reg                        ack_list_loaded_flag;
    reg                        ack_list_processed_flag;
    reg                        ack_pending;

    ////////////////////////////////////////////////////////////////////////////
    // Decode of the held command byte.
    wire                       cmd_is_write = cmd[`HBR_CMD_WRITE_BIT];
    wire [6:0]                 cmd_index    = cmd[6:0];
    wire                       port_iso     = (cmd_index == `HBR_CMD_ISO_PORT);
    wire                       port_ack     = (cmd_index == `HBR_CMD_ACK_PORT);
    wire                       port_sel     = port_iso | port_ack;

    wire [15:0]                host_irq_status;
    wire [15:0]                buffer_state_register;
    assign host_irq_status = {13'h0000, all_transfers_done_flag, ack_list_ready_flag, 1'b0};
    assign buffer_state_register = {10'h000, ack_list_processed_flag, iso_half_b_done,
                                    iso_half_a_done, ack_list_loaded_flag,
                                    iso_half_b_full, iso_half_a_full};

    // Area base: ack list first, then two iso halves of equal length.
    wire [`HBR_LEN_W-1:0]      iso_base  = ack_len + (iso_cpu_half ? iso_len
                                                                   : {`HBR_LEN_W{1'b0}});
    wire [`HBR_LEN_W-1:0]      area_base = port_iso ? iso_base : {`HBR_LEN_W{1'b0}};
    wire [`HBR_LEN_W-1:0]      acc_addr  = area_base + ptr;
    wire [`HBR_LEN_W-1:0]      next_ptr  = ptr + 13'h0002;

    // Count rounded up to even, since the pointer only steps in pairs.
    wire [`HBR_LEN_W-1:0]      cnt_even  = transfer_byte_count[12:0]
                                           + {12'h000, transfer_byte_count[0]};
    wire                       hit_end   = (next_ptr == cnt_even);

    ////////////////////////////////////////////////////////////////////////////
    // Processor strobes, split into port and register traffic.
    wire                       fifo_out_valid;
    wire [FW-1:0]              fifo_out_data;
    wire                       drain = fifo_out_valid & ~engine_ram_busy;
    wire                       port_wr = data_wr & cmd_is_write & port_sel;
    wire                       port_wr_fire = port_wr & wr_ready;
    wire                       reg_wr = data_wr & cmd_is_write & ~port_sel;
    // Reads are ignored until every pending write has reached the RAM.
    wire                       rd_fire = data_rd & ~cmd_is_write & ~fifo_out_valid;
    wire                       port_rd = rd_fire & port_sel;

    // FIFO word: last-of-transfer, iso list, iso half, word address, data.
    wire [FW-1:0]              fifo_in_data = {hit_end, port_iso, iso_cpu_half,
                                               acc_addr[`HBR_ADDR_W-1:1], data_in};
    wire                       drain_last = drain & fifo_out_data[29];
    wire                       drain_iso  = fifo_out_data[28];
    wire                       drain_half = fifo_out_data[27];

    wire [15:0]                ram_rd_data;

    // Half the processor sees after this cycle's possible frame swap.
    reg                        next_half;
    always @* begin
        next_half = iso_cpu_half;
        if (sof) begin
            if (iso_half_a_full & iso_half_b_full) begin
                next_half = 1'b1;
            end else begin
                next_half = ~iso_cpu_half;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command byte, pointer and configuration registers.
    always @(posedge clk) begin
        if (rst) begin
            cmd                 <= 8'h00;
            ptr                 <= {`HBR_LEN_W{1'b0}};
            transfer_byte_count <= `HBR_XFER_CNT_RST;
            ack_len             <= `HBR_ACK_LEN_RST;
            iso_len             <= `HBR_ISO_LEN_RST;
        end else begin
            if (cmd_wr) begin
                cmd <= data_in[7:0];
                ptr <= {`HBR_LEN_W{1'b0}};
            end else if (port_wr_fire | port_rd) begin
                ptr <= next_ptr;
            end
            // Write code equals the read code with bit 7 set.
            if (reg_wr) begin
                case (cmd_index)
                    `HBR_CMD_XFER_COUNT: transfer_byte_count <= data_in;
                    // Lengths keep 4-byte granularity so every area starts aligned.
                    `HBR_CMD_ISO_LENGTH: iso_len <= {data_in[12:2], 2'b00};
                    `HBR_CMD_ACK_LENGTH: ack_len <= {data_in[12:2], 2'b00};
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read answers: one cycle after the strobe, from register or buffer RAM.
    always @(posedge clk) begin
        if (rst) begin
            data_out       <= 16'h0000;
            data_out_valid <= 1'b0;
            idle           <= 1'b1;
        end else begin
            data_out_valid <= rd_fire;
            idle           <= ~fifo_out_valid & ~port_wr_fire;
            if (rd_fire) begin
                case (cmd_index)
                    `HBR_CMD_XFER_COUNT: data_out <= transfer_byte_count;
                    `HBR_CMD_IRQ_STATUS: data_out <= host_irq_status;
                    `HBR_CMD_ISO_LENGTH: data_out <= {3'b000, iso_len};
                    `HBR_CMD_ACK_LENGTH: data_out <= {3'b000, ack_len};
                    `HBR_CMD_BUF_STATE:  data_out <= buffer_state_register;
                    `HBR_CMD_ISO_PORT:   data_out <= ram_rd_data;
                    `HBR_CMD_ACK_PORT:   data_out <= ram_rd_data;
                    default:             data_out <= 16'h0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt and buffer flags; clears are written first so sets win.
    always @(posedge clk) begin
        if (rst) begin
            ack_list_ready_flag     <= 1'b0;
            all_transfers_done_flag <= 1'b0;
            iso_half_a_full         <= 1'b0;
            iso_half_b_full         <= 1'b0;
            iso_half_a_done         <= 1'b0;
            iso_half_b_done         <= 1'b0;
            ack_list_loaded_flag    <= 1'b0;
            ack_list_processed_flag <= 1'b0;
        end else begin
            // Software clears interrupt bits by writing ones.
            if (reg_wr && cmd_index == `HBR_CMD_IRQ_STATUS) begin
                if (data_in[`HBR_IRQ_ACK_READY]) ack_list_ready_flag <= 1'b0;
                if (data_in[`HBR_IRQ_ALL_DONE])  all_transfers_done_flag <= 1'b0;
            end
            // Any read of a visible iso half releases it for new data.
            if (port_rd && port_iso) begin
                if (iso_cpu_half) begin
                    iso_half_b_full <= 1'b0;
                    iso_half_b_done <= 1'b0;
                end else begin
                    iso_half_a_full <= 1'b0;
                    iso_half_a_done <= 1'b0;
                end
            end
            // Reading the ack list back to its end empties it.
            if (port_rd && port_ack && hit_end) begin
                ack_list_loaded_flag    <= 1'b0;
                ack_list_processed_flag <= 1'b0;
            end
            // End of transfer is taken when the last pair lands or is read.
            if (drain_last || (port_rd && hit_end)) begin
                all_transfers_done_flag <= 1'b1;
            end
            if (drain_last && !drain_iso) begin
                ack_list_loaded_flag <= 1'b1;
            end
            if (drain_last && drain_iso) begin
                if (drain_half) iso_half_b_full <= 1'b1;
                else            iso_half_a_full <= 1'b1;
            end
            // Engine results count only while the controller is operational.
            if (engine_ack_done && operational_state) begin
                ack_list_processed_flag <= 1'b1;
                ack_list_ready_flag     <= 1'b1;
            end
            if (engine_iso_done && operational_state) begin
                if (iso_cpu_half) iso_half_a_done <= 1'b1;
                else              iso_half_b_done <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Ping-pong selection and engine start pulses.
    always @(posedge clk) begin
        if (rst) begin
            iso_cpu_half <= 1'b0;
            iso_start    <= 1'b0;
            ack_start    <= 1'b0;
            ack_pending  <= 1'b0;
        end else begin
            iso_cpu_half <= next_half;
            // Engine takes the half the processor no longer sees.
            iso_start <= sof & operational_state & (next_half ? iso_half_a_full
                                                              : iso_half_b_full);
            // One start per loaded list; a stopped controller sends nothing.
            ack_start <= 1'b0;
            if (engine_ack_done | ~operational_state) begin
                ack_pending <= 1'b0;
            end else if (operational_state & ack_list_loaded_flag
                         & ~ack_list_processed_flag & ~ack_pending) begin
                ack_start   <= 1'b1;
                ack_pending <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write path: FIFO absorbs bursts while the engine holds the RAM.
    hbr_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH),
        .AW    (3)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (port_wr),
        .in_ready  (wr_ready),
        .in_data   (fifo_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (~engine_ram_busy),
        .out_data  (fifo_out_data)
    );

    hbr_word_ram #(
        .BYTES (RAM_BYTES),
        .WAW   (11)
    ) u_ram (
        .clk     (clk),
        .wr_en   (drain),
        .wr_addr (fifo_out_data[26:16]),
        .wr_data (fifo_out_data[15:0]),
        .rd_addr (acc_addr[`HBR_ADDR_W-1:1]),
        .rd_data (ram_rd_data)
    );

endmodule // hbr_access_port

// ==== tb/hbr_access_port_monitor.sv ====
// Concurrent checks on the ports of the host buffer RAM access port.
`timescale 1ns/1ps
module hbr_access_port_monitor (
    input wire        clk,
    input wire        rst,
    input wire        cmd_wr,
    input wire        data_wr,
    input wire        data_rd,
    input wire [15:0] data_in,
    input wire [15:0] data_out,
    input wire        data_out_valid,
    input wire        wr_ready,
    input wire        idle,
    input wire        operational_state,
    input wire        sof,
    input wire        engine_ram_busy,
    input wire        engine_ack_done,
    input wire        engine_iso_done,
    input wire        ack_start,
    input wire        iso_start,
    input wire        iso_cpu_half
);
    reg  [7:0] cmd_q;
    wire       wr_cmd;
    // Held command byte, so that data strobes can be classified as read or write.
    always @(posedge clk) begin
        if (rst)
            cmd_q <= 8'h00;
        else if (cmd_wr)
            cmd_q <= data_in[7:0];
    end
    assign wr_cmd = cmd_q[7];
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////
    a_read_answer: assert property (data_rd && !wr_cmd && idle |=> data_out_valid)
        else $error("read not answered one cycle later");
    a_valid_cause: assert property (data_out_valid |-> $past(data_rd) && !$past(wr_cmd))
        else $error("answer without a read");
    a_write_silent: assert property (data_rd && wr_cmd |=> !data_out_valid)
        else $error("read strobe under a write command answered");
    a_out_held: assert property (!$stable(data_out) |-> data_out_valid)
        else $error("read data changed without an answer");
    a_idle_drops: assert property (data_wr && cmd_q == 8'hC1 && wr_ready |-> ##[1:3] !idle)
        else $error("accepted port write never seen pending");
    a_start_oper: assert property (ack_start |-> $past(operational_state))
        else $error("list traffic started while not operational");
    a_start_pulse: assert property (ack_start |=> !ack_start)
        else $error("list start longer than one cycle");
    a_half_sof: assert property (!$stable(iso_cpu_half) |-> $past(sof))
        else $error("visible half changed without frame start");
    a_iso_start: assert property (iso_start |-> $past(sof) && $past(operational_state))
        else $error("iso start without frame start while operational");
    a_reset_state: assert property (disable iff (1'b0)
        rst |=> wr_ready && idle && !data_out_valid && !ack_start && !iso_cpu_half)
        else $error("outputs not at reset values");
    c_answer: cover property (data_out_valid);
    c_full: cover property (!wr_ready);
    c_held: cover property (sof && iso_cpu_half ##1 iso_cpu_half);
    c_start: cover property (ack_start);
endmodule // hbr_access_port_monitor

bind hbr_access_port hbr_access_port_monitor i_hbr_access_port_monitor (
    .clk(clk), .rst(rst), .cmd_wr(cmd_wr), .data_wr(data_wr), .data_rd(data_rd),
    .data_in(data_in), .data_out(data_out), .data_out_valid(data_out_valid),
    .wr_ready(wr_ready), .idle(idle), .operational_state(operational_state), .sof(sof),
    .engine_ram_busy(engine_ram_busy), .engine_ack_done(engine_ack_done),
    .engine_iso_done(engine_iso_done), .ack_start(ack_start), .iso_start(iso_start),
    .iso_cpu_half(iso_cpu_half));

// ==== tb/hbr_cpu_model.sv ====
// Processor model driving the command and data strobes of the access port.
`timescale 1ns/1ps
module hbr_cpu_model (
    input  wire        clk,
    output reg         cmd_wr,
    output reg         data_wr,
    output reg         data_rd,
    output reg  [15:0] data_in,
    input  wire [15:0] data_out,
    input  wire        data_out_valid,
    input  wire        wr_ready,
    input  wire        idle,
    output reg         hung
);
    integer n;
    initial begin
        cmd_wr = 1'b0;
        data_wr = 1'b0;
        data_rd = 1'b0;
        data_in = 16'hA5A5;
        hung = 1'b0;
    end
    // Bounded wait on a level sampled at the falling edge, clear of update races.
    task wait_hi(input sel);
        begin
            @(negedge clk);
            for (n = 0; n < 500 && (sel ? idle : wr_ready) !== 1'b1; n = n + 1)
                @(negedge clk);
            if (n == 500)
                hung = 1'b1;
        end
    endtask
    // A command byte is sent once; the bus then shows its inverse, not a held value.
    task cmd(input [7:0] c);
        begin
            @(posedge clk);
            cmd_wr <= 1'b1;
            data_in <= {8'h00, c};
            @(posedge clk);
            cmd_wr <= 1'b0;
            data_in <= {8'hFF, ~c};
        end
    endtask
    task wr(input [15:0] d);
        begin
            wait_hi(1'b0);
            @(posedge clk);
            data_wr <= 1'b1;
            data_in <= d;
            @(posedge clk);
            data_wr <= 1'b0;
            data_in <= ~d;
        end
    endtask
    // Reads wait for pending writes to drain, since a read then is ignored.
    task rd(output [15:0] v);
        begin
            wait_hi(1'b1);
            @(posedge clk);
            data_rd <= 1'b1;
            @(posedge clk);
            data_rd <= 1'b0;
            #1;
            v = data_out_valid ? data_out : 16'hXXXX;
        end
    endtask
endmodule // hbr_cpu_model

// ==== tb/testbench.sv ====
// Self-checking bench for the host buffer RAM access port.
`timescale 1ns/1ps
module testbench;
    reg        clk, rst, operational_state, sof, engine_ram_busy, engine_ack_done;
    reg        engine_iso_done;
    wire       cmd_wr, data_wr, data_rd, data_out_valid, wr_ready, idle, hung;
    wire       ack_start, iso_start, iso_cpu_half;
    wire [15:0] data_in, data_out;
    integer    err_count, n_compared, i, acc, n_start, n_iso;
    reg [15:0] v;
    reg [40:0] rows [0:8];
    hbr_access_port i_hbr_access_port (
        .clk(clk), .rst(rst), .cmd_wr(cmd_wr), .data_wr(data_wr), .data_rd(data_rd),
        .data_in(data_in), .data_out(data_out), .data_out_valid(data_out_valid),
        .wr_ready(wr_ready), .idle(idle), .operational_state(operational_state), .sof(sof),
        .engine_ram_busy(engine_ram_busy), .engine_ack_done(engine_ack_done),
        .engine_iso_done(engine_iso_done), .ack_start(ack_start), .iso_start(iso_start),
        .iso_cpu_half(iso_cpu_half));
    hbr_cpu_model i_hbr_cpu_model (
        .clk(clk), .cmd_wr(cmd_wr), .data_wr(data_wr), .data_rd(data_rd), .data_in(data_in),
        .data_out(data_out), .data_out_valid(data_out_valid), .wr_ready(wr_ready),
        .idle(idle), .hung(hung));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Word k carries buffer bytes 2k (low lane) and 2k+1 (high lane).
    function [15:0] word(input integer k);
        word = {k[6:0], 1'b1, k[6:0], 1'b0};
    endfunction
    task chk(input [15:0] got, input [15:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task report_and_stop;
        begin
            if (err_count == 0 && n_compared > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task regw(input [7:0] c, input [15:0] d);
        begin
            i_hbr_cpu_model.cmd(c | 8'h80);
            i_hbr_cpu_model.wr(d);
        end
    endtask
    task regr(input [7:0] c, input [15:0] exp);
        begin
            i_hbr_cpu_model.cmd(c);
            i_hbr_cpu_model.rd(v);
            chk(v, exp);
        end
    endtask
    // One-cycle pulse: 0 frame start, 1 list processed, 2 iso half processed.
    task pulse(input [1:0] s);
        begin
            @(posedge clk);
            sof             <= (s == 2'd0);
            engine_ack_done <= (s == 2'd1);
            engine_iso_done <= (s == 2'd2);
            @(posedge clk);
            sof             <= 1'b0;
            engine_ack_done <= 1'b0;
            engine_iso_done <= 1'b0;
            @(negedge clk);
        end
    endtask
    // A stuck handshake or an overlong run ends in the same report.
    always @(posedge hung) begin
        err_count = err_count + 1;
        report_and_stop;
    end
    // Engine start pulses are counted so that every one of them is accounted for.
    always @(posedge clk) begin
        if (ack_start === 1'b1)
            n_start <= n_start + 1;
        if (iso_start === 1'b1)
            n_iso <= n_iso + 1;
    end
    initial begin
        #400000;
        err_count = err_count + 1;
        report_and_stop;
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        err_count = 0;
        n_compared = 0;
        n_start = 0;
        n_iso = 0;
        rst = 1'b1;
        operational_state = 1'b0;
        sof = 1'b0;
        engine_ram_busy = 1'b0;
        engine_ack_done = 1'b0;
        engine_iso_done = 1'b0;
        rows[0] = {1'b0, 8'h22, 16'h0000, 16'h0000};
        rows[1] = {1'b0, 8'h2B, 16'h0000, 16'h1000};
        rows[2] = {1'b0, 8'h2A, 16'h0000, 16'h0000};
        rows[3] = {1'b0, 8'h2C, 16'h0000, 16'h0000};
        rows[4] = {1'b0, 8'h24, 16'h0000, 16'h0000};
        rows[5] = {1'b1, 8'h2B, 16'h0802, 16'h0800};
        rows[6] = {1'b1, 8'h2A, 16'h0403, 16'h0400};
        rows[7] = {1'b0, 8'h30, 16'h0000, 16'h0000};
        rows[8] = {1'b1, 8'h22, 16'h0020, 16'h0020};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        // Reset values, then length writes that drop the unaligned bits.
        for (i = 0; i < 9; i = i + 1) begin
            if (rows[i][40])
                regw(rows[i][39:32], rows[i][31:16]);
            regr(rows[i][39:32], rows[i][15:0]);
        end
        // Stall the drain while not operational and fill the FIFO until it refuses.
        engine_ram_busy <= 1'b1;
        i_hbr_cpu_model.cmd(8'hC1);
        acc = 0;
        for (i = 0; i < 12; i = i + 1) begin
            @(negedge clk);
            if (wr_ready === 1'b1) begin
                i_hbr_cpu_model.wr(word(acc));
                acc = acc + 1;
            end
        end
        chk(acc[15:0], 16'h0008);
        chk({14'h0000, wr_ready, idle}, 16'h0000);
        engine_ram_busy <= 1'b0;
        for (i = 8; i < 16; i = i + 1)
            i_hbr_cpu_model.wr(word(i));
        regr(8'h24, 16'h0004);
        regr(8'h2C, 16'h0004);
        chk(n_start[15:0], 16'h0000);
        // Read back, re-issue the command after three words: the pointer restarts.
        i_hbr_cpu_model.cmd(8'h41);
        for (i = 0; i < 19; i = i + 1) begin
            if (i == 3)
                i_hbr_cpu_model.cmd(8'h41);
            i_hbr_cpu_model.rd(v);
            chk(v, word(i < 3 ? i : i - 3));
        end
        regr(8'h2C, 16'h0000);
        // Operational: one aligned 8-byte header is loaded and processed.
        operational_state <= 1'b1;
        regw(8'h24, 16'h0004);
        regw(8'h22, 16'h0008);
        i_hbr_cpu_model.cmd(8'hC1);
        for (i = 0; i < 4; i = i + 1)
            i_hbr_cpu_model.wr(word(i));
        for (i = 0; i < 50 && n_start == 0; i = i + 1)
            @(negedge clk);
        chk(n_start[15:0], 16'h0001);
        pulse(2'd1);
        regr(8'h24, 16'h0006);
        regr(8'h2C, 16'h0024);
        regw(8'h24, 16'h0006);
        regr(8'h24, 16'h0000);
        // Ping-pong: fill both halves, the swap stops, reading one half frees it.
        regw(8'h22, 16'h0004);
        i_hbr_cpu_model.cmd(8'hC0);
        i_hbr_cpu_model.wr(word(0));
        i_hbr_cpu_model.wr(word(1));
        pulse(2'd0);
        chk({15'h0000, iso_cpu_half}, 16'h0001);
        pulse(2'd2);
        i_hbr_cpu_model.cmd(8'hC0);
        i_hbr_cpu_model.wr(word(2));
        i_hbr_cpu_model.wr(word(3));
        regr(8'h2C, 16'h002F);
        pulse(2'd0);
        chk({15'h0000, iso_cpu_half}, 16'h0001);
        regr(8'h40, word(2));
        regr(8'h2C, 16'h002D);
        pulse(2'd0);
        chk({15'h0000, iso_cpu_half}, 16'h0000);
        // Half a was taken at the first two frame starts, half b was empty at the third.
        chk(n_iso[15:0], 16'h0002);
        // Second reset in mid-run restores the lengths.
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        regr(8'h2B, 16'h1000);
        report_and_stop;
    end
endmodule // testbench
